// ==== rtl/rwseq_pkg.sv ====
// Shared constants and carrier types for the reset and watchdog sequencer
`default_nettype none
package rwseq_pkg;
   // Low interrupt vector area: six 16-bit vectors, reset vector just above
   localparam int VEC_COUNT = 6;
   localparam int VEC_BYTES = 2;
   localparam logic [15:0] RESET_VECTOR = 16'(VEC_COUNT * VEC_BYTES);

   // Core clock cycles added after the power-on delay
   localparam logic [4:0] EXT_CYCLES = 5'h12;

   // Free-running RC oscillator rate, seen as one tick pulse per period
   localparam int RC_FREQ_HZ = 32768;
   // Power-on delay in RC ticks (no figure is fixed; plain default)
   localparam logic [15:0] POD_TICKS = 16'h0010;
   // Watchdog least timeout in ms, rounded up to whole RC ticks
   localparam int WD_TIMEOUT_MS = 12;
   localparam logic [15:0] WD_TICKS = 16'((WD_TIMEOUT_MS * RC_FREQ_HZ + 999) / 1000);

   // Sequencer states
   typedef enum logic [1:0] {
      ST_DELAY,
      ST_EXTEND,
      ST_RUN
   } rwseq_state_e;

   // Instruction strobes and sleep status from the processor core
   typedef struct packed {
      logic watchdog_refresh_instr;
      logic watchdog_halt_enable_instr;
      logic halted;
      logic stopped;
   } rwseq_core_s;
endpackage
`default_nettype wire

// ==== rtl/rwseq_top.sv ====
// Power-on reset one-shot and watchdog one-shot driving the core reset
// What this block does
// (R1) Internal reset only from power-on or watchdog
// (R2) Delay plus 18 cycles, then start at 000C
// (R3) Power-on delay timed by RC oscillator ticks
// (R4) Four events fire the power-on one-shot
// (R5) Watchdog terminal count resets the microcontroller
// (R6) First refresh starts watchdog; later refreshes clear it
// (R7) Watchdog counts RC ticks, not core clock
// (R8) Watchdog timeout at least 12 ms
// (R9) Reset vector sits above twelve vector bytes
// (R10) Started watchdog cannot be stopped by software
// (R11) Software watchdog idles in stop, halt unless enabled
// (R12) Halt enable needs started watchdog, keeps count
// (R13) Permanent option: always runs after reset
// (R14) Hold reset throughout, release on core clock
// (R15) Retrigger during delay restarts the delay
`timescale 1ns/1ps
`default_nettype none

module rwseq_top (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // RC oscillator tick and power status
   input wire logic rc_tick,
   input wire logic power_good,
   input wire logic stop_recovery,
   // Permanent watchdog option
   input wire logic perm_wdt_opt,
   // Core strobes and status
   input wire rwseq_pkg::rwseq_core_s core,
   // Outputs to the core
   output logic core_rst,
   output logic [15:0] reset_vector,
   output logic wdt_running,
   output logic wdt_timeout
);

   rwseq_pkg::rwseq_state_e state;
   rwseq_pkg::rwseq_state_e next_state;
   logic [15:0] delay_cnt;
   logic [4:0] ext_cnt;
   logic [15:0] wd_cnt;
   logic wd_sw_en;
   logic wd_halt_ok;
   logic power_good_q;
   logic wd_run;
   logic wd_hit;
   logic por_fire;

   // Watchdog runs if permanent, or started and not parked by sleep
   always_comb begin
      wd_run = 1'b0;
      if (state == rwseq_pkg::ST_RUN) begin
         if (perm_wdt_opt) begin
            wd_run = 1'b1; // R13
         end else begin
            wd_run = wd_sw_en && !core.stopped && (!core.halted || wd_halt_ok); // R11
         end
      end
   end

   // Terminal count on the RC tick that completes the period
   assign wd_hit = wd_run && rc_tick && !core.watchdog_refresh_instr
      && (wd_cnt == rwseq_pkg::WD_TICKS - 16'h0001); // R5 R8

   // Power-good edge, low power-good, stop recovery or watchdog (also in halt) fire the one-shot
   assign por_fire = (power_good && !power_good_q) || stop_recovery || wd_hit
      || !power_good; // R1 R4

   // Next state: restart on any trigger, otherwise walk the sequence
   always_comb begin
      next_state = state;
      if (por_fire) begin
         next_state = rwseq_pkg::ST_DELAY; // R15
      end else begin
         case (state)
            rwseq_pkg::ST_DELAY: begin
               if (rc_tick && delay_cnt == rwseq_pkg::POD_TICKS - 16'h0001) begin
                  next_state = rwseq_pkg::ST_EXTEND;
               end
            end
            rwseq_pkg::ST_EXTEND: begin
               if (ext_cnt == rwseq_pkg::EXT_CYCLES - 5'h01) begin
                  next_state = rwseq_pkg::ST_RUN;
               end
            end
            default: begin
               next_state = rwseq_pkg::ST_RUN;
            end
         endcase
      end
   end

   // Sequencer state and registered reset output
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= rwseq_pkg::ST_DELAY;
         core_rst <= 1'b1;
      end else if (clk_en) begin
         state <= next_state;
         core_rst <= (next_state != rwseq_pkg::ST_RUN); // R14
      end
   end

   // Power-good history for edge detection; starts as bad
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         power_good_q <= 1'b0;
      end else if (clk_en) begin
         power_good_q <= power_good;
      end
   end

   // Power-on delay counts RC ticks so it works before the crystal settles
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         delay_cnt <= 16'h0000;
      end else if (clk_en) begin
         if (por_fire || state != rwseq_pkg::ST_DELAY) begin
            delay_cnt <= 16'h0000; // R15
         end else if (rc_tick) begin
            delay_cnt <= delay_cnt + 16'h0001; // R3
         end
      end
   end

   // Extension counts core clock cycles after the delay
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ext_cnt <= 5'h00;
      end else if (clk_en) begin
         if (state == rwseq_pkg::ST_EXTEND && !por_fire) begin
            ext_cnt <= ext_cnt + 5'h01; // R2
         end else begin
            ext_cnt <= 5'h00;
         end
      end
   end

   // Software enable is sticky until an internal reset; no way to clear it
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wd_sw_en <= 1'b0;
         wd_halt_ok <= 1'b0;
      end else if (clk_en) begin
         if (state != rwseq_pkg::ST_RUN || por_fire) begin
            wd_sw_en <= 1'b0;
            wd_halt_ok <= 1'b0;
         end else begin
            if (core.watchdog_refresh_instr) begin
               wd_sw_en <= 1'b1; // R6 R10
            end
            if (core.watchdog_halt_enable_instr && wd_sw_en) begin
               wd_halt_ok <= 1'b1; // R12
            end
         end
      end
   end

   // Watchdog counter on RC ticks; survives a stopped crystal in real silicon
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wd_cnt <= 16'h0000;
      end else if (clk_en) begin
         if (state != rwseq_pkg::ST_RUN || por_fire || core.watchdog_refresh_instr) begin
            wd_cnt <= 16'h0000; // R6
         end else if (wd_run && rc_tick) begin
            wd_cnt <= wd_cnt + 16'h0001; // R7
         end
      end
   end

   // Status outputs, all registered
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wdt_running <= 1'b0;
         wdt_timeout <= 1'b0;
         reset_vector <= 16'h0000;
      end else if (clk_en) begin
         wdt_running <= wd_run;
         wdt_timeout <= wd_hit; // R5
         reset_vector <= rwseq_pkg::RESET_VECTOR; // R9
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   a_rst_cause: assert property ($rose(core_rst) |-> $past(por_fire)) // R1
      else $error("Core reset rose without a trigger");
   a_ext_length: assert property ( // R2
      $fell(core_rst) |-> $past(ext_cnt) == rwseq_pkg::EXT_CYCLES - 5'h01)
      else $error("Extension length wrong at release");
   a_vector_value: assert property ( // R9
      $fell(core_rst) |-> reset_vector == 16'h000C)
      else $error("Reset vector wrong at release");
   a_delay_restart: assert property ( // R15
      clk_en && por_fire |=> state == rwseq_pkg::ST_DELAY && delay_cnt == 16'h0000
      && core_rst)
      else $error("Trigger did not restart delay");
   a_delay_ticks: assert property ( // R3
      clk_en && state == rwseq_pkg::ST_DELAY && !por_fire && !rc_tick
      |=> $stable(delay_cnt))
      else $error("Delay moved without RC tick");
   a_refresh_clear: assert property ( // R6
      clk_en && core.watchdog_refresh_instr |=> wd_cnt == 16'h0000)
      else $error("Refresh did not clear watchdog");
   a_wd_fires: assert property (clk_en && wd_hit |=> core_rst && wdt_timeout) // R5
      else $error("Terminal count did not reset");
   a_wd_sticky: assert property ( // R10
      clk_en && wd_sw_en && !por_fire && state == rwseq_pkg::ST_RUN |=> wd_sw_en)
      else $error("Started watchdog was stopped");
   a_stop_parks: assert property ( // R11
      clk_en && core.stopped && !perm_wdt_opt && !por_fire
      && !core.watchdog_refresh_instr |=> $stable(wd_cnt))
      else $error("Software watchdog ran in stop");
   a_halt_noeffect: assert property ( // R12
      clk_en && !wd_sw_en && !wd_halt_ok |=> !wd_halt_ok)
      else $error("Halt enable took effect unstarted");
   a_perm_runs: assert property ( // R13
      clk_en && perm_wdt_opt && state == rwseq_pkg::ST_RUN && !por_fire && rc_tick
      && !core.watchdog_refresh_instr |=> wd_cnt == $past(wd_cnt) + 16'h0001)
      else $error("Permanent watchdog did not count");
   // Ticks counted at terminal count, turned into time, must cover the minimum
   a_period_min: assert property ( // R8
      clk_en && wd_hit |-> (int'(wd_cnt) + 1) * 1000
      >= rwseq_pkg::WD_TIMEOUT_MS * rwseq_pkg::RC_FREQ_HZ)
      else $error("Watchdog period short");

   c_release: cover property ($fell(core_rst));
   c_wd_timeout: cover property (wd_hit);
   c_retrigger: cover property (state == rwseq_pkg::ST_DELAY && delay_cnt != 16'h0000
      && por_fire);
   c_halt_run: cover property (wd_run && core.halted);

endmodule

`default_nettype wire

// ==== verification/rwseq_core_model.sv ====
// Processor core model: instruction strobes and sleep levels
`timescale 1ns/1ps
`default_nettype none
module rwseq_core_model #(
   parameter int PERIOD = 200
) (
   // Clock and core reset
   input wire logic clk,
   input wire logic core_rst,
   // Requests from the bench
   input wire logic do_ref,
   input wire logic do_hen,
   input wire logic kick,
   input wire logic hlt,
   input wire logic stp,
   // Strobes and levels to the sequencer
   output var rwseq_pkg::rwseq_core_s core
);
   int cnt;

   // Periodic refresh spacing, well inside the timeout
   always_ff @(posedge clk) begin
      cnt <= (core_rst || !kick || cnt == PERIOD - 1) ? 0 : cnt + 1;
   end

   // A core held in reset executes nothing
   always_comb begin
      core.watchdog_refresh_instr = !core_rst && (do_ref || (kick && cnt == PERIOD - 1));
      core.watchdog_halt_enable_instr = !core_rst && do_hen;
      core.halted = hlt;
      core.stopped = stp;
   end
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench for the reset and watchdog sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int PD = 2 * rwseq_pkg::POD_TICKS + 18;
   localparam int WD = 2 * rwseq_pkg::WD_TICKS;
   logic clk = 0, sys_rst = 1, rc_tick = 0, power_good = 1, stop_recovery = 0;
   logic perm_wdt_opt = 0, do_ref = 0, do_hen = 0, kick = 0, hlt = 0, stp = 0;
   logic clk_en = 1;
   logic core_rst, wdt_running, wdt_timeout;
   logic [15:0] reset_vector;
   rwseq_pkg::rwseq_core_s core;
   int n_mismatch = 0, comparisons = 0, n, t;
   // Nibbles: option, refresh, halt enable, halted, stopped, periodic, timeout
   logic [27:0] rows [9] = '{28'h000_0000, 28'h010_0001, 28'h010_0100, 28'h010_1000,
      28'h011_1001, 28'h001_1000, 28'h000_0010, 28'h100_0101, 28'h100_1001};

   // Core clock, and an RC tick every other cycle so the two differ
   always #20 clk = ~clk;
   always @(posedge clk) rc_tick <= ~rc_tick;

   rwseq_top dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .rc_tick(rc_tick),
      .power_good(power_good), .stop_recovery(stop_recovery), .perm_wdt_opt(perm_wdt_opt),
      .core(core), .core_rst(core_rst), .reset_vector(reset_vector),
      .wdt_running(wdt_running), .wdt_timeout(wdt_timeout));
   rwseq_core_model core_m (.clk(clk), .core_rst(core_rst), .do_ref(do_ref),
      .do_hen(do_hen), .kick(kick), .hlt(hlt), .stp(stp), .core(core));

   task automatic test_done;
      $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e, g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask

   function automatic logic [15:0] inr(input int v, lo, hi);
      return 16'(v >= lo && v <= hi);
   endfunction

   // Edges until the core is let go, bounded
   task automatic rel(output int c);
      c = 0;
      #1;
      while (core_rst !== 1'b0 && c < 300) begin
         @(posedge clk);
         #1;
         c++;
      end
   endtask

   // Edges until a watchdog timeout, bounded past the period
   task automatic wdw(output int c);
      c = 0;
      while (wdt_timeout !== 1'b1 && c < WD + 40) begin
         @(posedge clk);
         #1;
         c++;
      end
   endtask

   task automatic pulse;
      @(posedge clk) stop_recovery <= 1'b1;
      @(posedge clk) stop_recovery <= 1'b0;
   endtask

   // Hang guard: all tests take near 8000 cycles
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      test_done();
   end

   // Main sequence
   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      rel(n);
      chk("vector", 16'h000C, reset_vector);
      foreach (rows[i]) begin
         @(posedge clk) perm_wdt_opt <= rows[i][24];
         pulse();
         rel(n);
         chk("delay", 16'h0001, inr(n, PD - 3, PD + 4));
         @(posedge clk) begin
            do_ref <= rows[i][20];
            kick <= rows[i][4];
         end
         @(posedge clk) begin
            do_ref <= 1'b0;
            do_hen <= rows[i][16];
         end
         @(posedge clk) begin
            do_hen <= 1'b0;
            hlt <= rows[i][12];
            stp <= rows[i][8];
         end
         // Running flag lags the sleep levels by one edge
         @(posedge clk);
         #1;
         chk("running", 16'(rows[i][0]), 16'(wdt_running));
         wdw(t);
         chk("timeout", 16'(rows[i][0]), 16'(t < WD + 40));
         if (rows[i][0]) begin
            chk("wd_time", 16'h0001, inr(t, WD - 12, WD + 4));
            chk("wd_reset", 16'h0001, 16'(core_rst));
         end
         @(posedge clk) begin
            hlt <= 1'b0;
            stp <= 1'b0;
            kick <= 1'b0;
         end
      end
      // Retrigger part way through the delay
      @(posedge clk) perm_wdt_opt <= 1'b0;
      pulse();
      repeat (20) @(posedge clk);
      pulse();
      rel(n);
      chk("retrigger", 16'h0001, inr(n, PD - 3, PD + 4));
      // A bad supply keeps the core held
      @(posedge clk) power_good <= 1'b0;
      repeat (100) @(posedge clk);
      #1;
      chk("held", 16'h0001, 16'(core_rst));
      @(posedge clk) power_good <= 1'b1;
      rel(n);
      chk("pg_delay", 16'h0001, inr(n, PD - 2, PD + 5));
      // Second reset in mid run
      @(posedge clk) sys_rst <= 1'b1;
      #1;
      chk("rst_core", 16'h0001, 16'(core_rst));
      chk("rst_vec", 16'h0000, reset_vector);
      @(posedge clk) sys_rst <= 1'b0;
      rel(n);
      chk("rst_delay", 16'h0001, inr(n, PD - 2, PD + 5));
      // Enable low freezes everything, so a trigger seen only then is lost
      @(posedge clk) begin
         clk_en <= 1'b0;
         stop_recovery <= 1'b1;
      end
      repeat (3) @(posedge clk);
      #1;
      chk("frozen", 16'h0000, 16'(core_rst));
      @(posedge clk) begin
         clk_en <= 1'b1;
         stop_recovery <= 1'b0;
      end
      repeat (2) @(posedge clk);
      #1;
      chk("thawed", 16'h0000, 16'(core_rst));
      test_done();
   end
endmodule
`default_nettype wire
